// ---- src/tal_pkg.sv ----
package tal_pkg;
  // ****************************************
  // Register pointers
  // ****************************************
  localparam logic [2:0] PtrCapab    = 3'h0;
  localparam logic [2:0] PtrSettings = 3'h1;
  localparam logic [2:0] PtrUpper    = 3'h2;
  localparam logic [2:0] PtrLower    = 3'h3;
  localparam logic [2:0] PtrCrit     = 3'h4;
  localparam logic [2:0] PtrAmbient  = 3'h5;
  localparam logic [2:0] PtrMaker    = 3'h6;
  localparam logic [2:0] PtrPart     = 3'h7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CapabReset    = 16'h000F;
  localparam logic [15:0] SettingsReset = 16'h0000;
  localparam logic [15:0] LimitReset    = 16'h0000;
  localparam logic [15:0] AmbientReset  = 16'h0000;

  // ****************************************
  // Settings field positions
  // ****************************************
  localparam int BitIntMode  = 0;
  localparam int BitPolHigh  = 1;
  localparam int BitCritOnly = 2;
  localparam int BitOutEn    = 3;
  localparam int BitStatus   = 4;
  localparam int BitIntClr   = 5;
  localparam int BitLockLo   = 6;
  localparam int BitLockHi   = 7;
  localparam int BitShutdown = 8;
  localparam int BitHystLo   = 9;
  localparam int BitHystHi   = 10;

  // ****************************************
  // Bus and timing
  // ****************************************
  localparam logic [6:0] AddrBase     = 7'h18;
  localparam int         ConvTimeUs   = 125;
  localparam int         ClkMhz       = 100;
  localparam int         ConvCycles   = ConvTimeUs * ClkMhz;
  localparam int         HostHalfDiv  = 4;
endpackage

// ---- src/tal_link_if.sv ----
// Two-wire link, open drain: an enable low pulls the wire low
interface tal_link_if;
  logic sclkDevOe;
  logic sdaDevOe;
  logic sclkHostOe;
  logic sdaHostOe;
  logic sclk;
  logic sda;
  assign sclk = sclkDevOe & sclkHostOe;
  assign sda  = sdaDevOe & sdaHostOe;
  modport dev  (input sclk, input sda, output sclkDevOe, output sdaDevOe);
  modport host (input sclk, input sda, output sclkHostOe, output sdaHostOe);
endinterface

// ---- src/tal_sync.sv ----
// Two-flop synchroniser for link lines
module tal_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Lines
  input  wire logic sclkIn,
  input  wire logic sdaIn,
  output logic      sclkOut,
  output logic      sdaOut
);
  logic [1:0] meta_r;
  logic [1:0] stab_r;

  // Meta then stable stage, lines idle high
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_r <= 2'h3;
      stab_r <= 2'h3;
    end else begin
      meta_r <= {sclkIn, sdaIn};
      stab_r <= meta_r;
    end
  end
  assign sclkOut = stab_r[1];
  assign sdaOut  = stab_r[0];
endmodule

// ---- src/tal_device.sv ----
// Notes on behaviour
// - Alert driven only when output enable set
// - Bit 0 picks comparator or latched interrupt
// - Bit 1 picks alert polarity
// - Above critical, alert acts as comparator
// - Below critical, selected mode returns
// - Bit 4 reads back alert state
// - Lock bits refuse limit writes
// - Critical-only: comparator on critical limit
// - Comparator alert held through shutdown
// - Comparator deasserts after clean conversion
// - Interrupt cleared by writing bit 5
// - Shutdown keeps latched interrupt
// - Clear during shutdown deasserts at once
// - Reset restores all defaults
// - Settings default all zero
// - Capability reads 000F
// - Limits and ambient reset to zero
// - Idle only when both lines high
// - Receiver acks each byte low
// - End of data: ack withheld
// - Bit 8 stops sampling, bus stays
// - Bits 10:9 set falling hysteresis
module tal_device #(
  parameter logic [15:0] MakerCode = 16'h1234, // Arbitrary value
  parameter logic [15:0] PartCode  = 16'h5A01, // Arbitrary value
  parameter int          ConvCyc   = tal_pkg::ConvCycles
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Link
  tal_link_if.dev          link,
  // Straps and sensor
  input  wire logic [2:0]  addrStrap,
  input  wire logic [15:0] sensorTemp,
  // Alert pin, open drain style level
  output logic             alertPin
);
  // Refuse a conversion time the counter cannot serve
  if (ConvCyc < 1) begin : g_conv_check
    $error("ConvCyc must be positive");
  end

  typedef enum {DsIdle, DsAddr, DsAckA, DsPtr, DsAckP, DsWrHi, DsAckH, DsWrLo,
                DsAckL, DsRdHi, DsRackH, DsRdLo, DsRackL, DsSkip} tal_dst_t;

  typedef struct packed {
    logic        sclkPrev;
    logic        sdaPrev;
    tal_dst_t    st;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        rd;
    logic [2:0]  ptr;
    logic [7:0]  hiByte;
    logic [15:0] txWord;
    logic        sdaOe;
    logic [15:0] settings;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
    logic [15:0] ambient;
    logic        latched;
    logic        cmpOut;
    logic [31:0] convCnt;
    logic        alertOn;
    logic        alertPin;
  } tal_dev_t;

  tal_dev_t s_r;
  tal_dev_t s_nxt;
  logic     sclkS;
  logic     sdaS;

  // Link input synchroniser
  tal_sync uSync (
    .mclk    (mclk),
    .reset   (reset),
    .sclkIn  (link.sclk),
    .sdaIn   (link.sda),
    .sclkOut (sclkS),
    .sdaOut  (sdaS)
  );

  // Hysteresis amount in quarter degrees shifted to bit 2
  function automatic logic signed [15:0] hystOf(input logic [1:0] sel);
    unique case (sel)
      2'h0: hystOf = 16'sh0000;
      2'h1: hystOf = 16'sh0018;
      2'h2: hystOf = 16'sh0030;
      default: hystOf = 16'sh0060;
    endcase
  endfunction

  // Signed thirteen-bit temperature, sign-extended
  function automatic logic signed [15:0] tempOf(input logic [15:0] v);
    tempOf = {{4{v[12]}}, v[11:0]};
  endfunction

  assign link.sclkDevOe = 1'b1;
  assign link.sdaDevOe  = s_r.sdaOe;
  assign alertPin       = s_r.alertPin;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic signed [15:0] ta;
    logic signed [15:0] hy;
    logic aboveUp;
    logic belowLo;
    logic aboveCr;
    logic rise;
    logic fall;
    logic startC;
    logic stopC;
    logic locked;
    logic isCmp;
    logic [15:0] wv;
    ta = 16'sh0000;
    hy = 16'sh0000;
    wv = 16'h0000;
    s_nxt = s_r;
    s_nxt.sclkPrev = sclkS;
    s_nxt.sdaPrev  = sdaS;
    rise   = sclkS & ~s_r.sclkPrev;
    fall   = ~sclkS & s_r.sclkPrev;
    startC = sclkS & s_r.sclkPrev & s_r.sdaPrev & ~sdaS;
    stopC  = sclkS & s_r.sclkPrev & ~s_r.sdaPrev & sdaS;
    locked = s_r.settings[tal_pkg::BitLockHi] & s_r.settings[tal_pkg::BitLockLo];

    // Sampling, stopped in shutdown
    if (!s_r.settings[tal_pkg::BitShutdown]) begin
      s_nxt.ambient = {3'h0, sensorTemp[12:2], 2'h0};
      s_nxt.convCnt = (s_r.convCnt >= 32'(ConvCyc)) ? s_r.convCnt : s_r.convCnt + 32'h1;
    end else begin
      s_nxt.convCnt = 32'h0;
    end

    // Limit comparison, falling hysteresis
    ta = tempOf(s_r.ambient);
    hy = s_r.cmpOut ? hystOf(s_r.settings[tal_pkg::BitHystHi:tal_pkg::BitHystLo]) : 16'sh0;
    aboveUp = ta > (tempOf(s_r.upper) - hy);
    belowLo = ta < tempOf(s_r.lower);
    aboveCr = ta > (tempOf(s_r.crit) - hy);
    if (s_r.settings[tal_pkg::BitCritOnly]) begin
      aboveUp = 1'b0;
      belowLo = 1'b0;
    end

    // Comparator with hold during shutdown and clean-conversion release
    if (aboveUp | belowLo | aboveCr) begin
      s_nxt.cmpOut = !s_r.settings[tal_pkg::BitShutdown] ? 1'b1 : s_r.cmpOut;
    end else if (!s_r.settings[tal_pkg::BitShutdown] && s_r.convCnt >= 32'(ConvCyc)) begin
      s_nxt.cmpOut = 1'b0;
    end

    // Interrupt latch sets on fresh event; set wins over clear
    isCmp = !s_r.settings[tal_pkg::BitIntMode] | s_r.settings[tal_pkg::BitCritOnly] | aboveCr;
    if (s_nxt.cmpOut & ~s_r.cmpOut) begin
      s_nxt.latched = 1'b1;
    end

    // ****************************************
    // Serial slave
    // ****************************************
    if (startC) begin
      s_nxt.st = DsAddr;
      s_nxt.bitCnt = 4'h0;
      s_nxt.sdaOe = 1'b1;
    end else if (stopC) begin
      s_nxt.st = DsIdle;
      s_nxt.sdaOe = 1'b1;
    end else if (rise) begin
      unique case (s_r.st)
        DsAddr, DsPtr, DsWrHi, DsWrLo: begin
          s_nxt.shift = {s_r.shift[6:0], sdaS};
          s_nxt.bitCnt = s_r.bitCnt + 4'h1;
        end
        DsRackH: if (sdaS) s_nxt.st = DsSkip;
        DsRackL: s_nxt.st = DsSkip;
        default: ;
      endcase
    end else if (fall) begin
      unique case (s_r.st)
        DsAddr: if (s_r.bitCnt == 4'h8) begin
          if (s_r.shift[7:1] == {tal_pkg::AddrBase[6:3], addrStrap}) begin
            s_nxt.rd = s_r.shift[0];
            s_nxt.st = DsAckA;
            s_nxt.sdaOe = 1'b0;
          end else begin
            s_nxt.st = DsSkip;
          end
        end
        DsAckA: begin
          s_nxt.bitCnt = 4'h0;
          if (s_r.rd) begin
            s_nxt.txWord = 16'h0000;
            unique case (s_r.ptr)
              tal_pkg::PtrCapab:    s_nxt.txWord = tal_pkg::CapabReset;
              tal_pkg::PtrSettings: s_nxt.txWord = s_r.settings;
              tal_pkg::PtrUpper:    s_nxt.txWord = s_r.upper;
              tal_pkg::PtrLower:    s_nxt.txWord = s_r.lower;
              tal_pkg::PtrCrit:     s_nxt.txWord = s_r.crit;
              tal_pkg::PtrAmbient:  s_nxt.txWord = s_r.ambient;
              tal_pkg::PtrMaker:    s_nxt.txWord = MakerCode;
              tal_pkg::PtrPart:     s_nxt.txWord = PartCode;
            endcase
            s_nxt.st = DsRdHi;
            s_nxt.sdaOe = s_nxt.txWord[15];
          end else begin
            s_nxt.st = DsPtr;
            s_nxt.sdaOe = 1'b1;
          end
        end
        DsPtr, DsWrHi, DsWrLo: if (s_r.bitCnt == 4'h8) begin
          s_nxt.sdaOe = 1'b0;
          s_nxt.st = (s_r.st == DsPtr) ? DsAckP : (s_r.st == DsWrHi) ? DsAckH : DsAckL;
          if (s_r.st == DsPtr) s_nxt.ptr = s_r.shift[2:0];
          if (s_r.st == DsWrHi) s_nxt.hiByte = s_r.shift;
        end
        DsAckP, DsAckH: begin
          s_nxt.sdaOe = 1'b1;
          s_nxt.bitCnt = 4'h0;
          s_nxt.st = (s_r.st == DsAckP) ? DsWrHi : DsWrLo;
        end
        DsAckL: begin
          s_nxt.sdaOe = 1'b1;
          s_nxt.st = DsSkip;
          wv = {s_r.hiByte, s_r.shift};
          unique case (s_r.ptr)
            tal_pkg::PtrSettings: begin
              s_nxt.settings = {5'h00, wv[10:9], wv[8], wv[7:5], 1'b0, wv[3:0]};
              if (locked) begin
                s_nxt.settings[tal_pkg::BitLockHi] = 1'b1;
                s_nxt.settings[tal_pkg::BitLockLo] = 1'b1;
                s_nxt.settings[tal_pkg::BitShutdown] = wv[8] & s_r.settings[8];
              end
              s_nxt.settings[tal_pkg::BitIntClr] = 1'b0;
              if (wv[tal_pkg::BitIntClr] && !(s_nxt.cmpOut & ~s_r.cmpOut)) begin
                s_nxt.latched = 1'b0;
              end
            end
            tal_pkg::PtrUpper: if (!locked) s_nxt.upper = {3'h0, wv[12:2], 2'h0};
            tal_pkg::PtrLower: if (!locked) s_nxt.lower = {3'h0, wv[12:2], 2'h0};
            tal_pkg::PtrCrit:  if (!locked) s_nxt.crit  = {3'h0, wv[12:2], 2'h0};
            default: ;
          endcase
        end
        DsRdHi, DsRdLo: begin
          s_nxt.bitCnt = s_r.bitCnt + 4'h1;
          s_nxt.txWord = {s_r.txWord[14:0], 1'b0};
          if (s_r.bitCnt == 4'h7) begin
            s_nxt.sdaOe = 1'b1;
            s_nxt.st = (s_r.st == DsRdHi) ? DsRackH : DsRackL;
          end else begin
            s_nxt.sdaOe = s_r.txWord[14];
          end
        end
        DsRackH: begin
          s_nxt.st = DsRdLo;
          s_nxt.bitCnt = 4'h0;
          s_nxt.sdaOe = s_r.txWord[15]; // Low byte MSB, not yet shifted
        end
        default: s_nxt.sdaOe = 1'b1;
      endcase
    end

    // Alert output
    s_nxt.alertOn = isCmp ? s_nxt.cmpOut : s_nxt.latched;
    s_nxt.settings[tal_pkg::BitStatus] = s_nxt.alertOn & s_r.settings[tal_pkg::BitOutEn];
    s_nxt.alertPin = s_r.settings[tal_pkg::BitOutEn] ?
                     (s_nxt.alertOn ~^ s_r.settings[tal_pkg::BitPolHigh]) :
                     ~s_r.settings[tal_pkg::BitPolHigh];
  end

  // State register; reset restores defaults
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r          <= '0;
      s_r.sclkPrev <= 1'b1;
      s_r.sdaPrev  <= 1'b1;
      s_r.st       <= DsIdle;
      s_r.sdaOe    <= 1'b1;
      s_r.settings <= tal_pkg::SettingsReset;
      s_r.upper    <= tal_pkg::LimitReset;
      s_r.lower    <= tal_pkg::LimitReset;
      s_r.crit     <= tal_pkg::LimitReset;
      s_r.ambient  <= tal_pkg::AmbientReset;
      s_r.alertPin <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ---- src/tal_host.sv ----
// Host end: register-port driven two-wire master
module tal_host (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Link
  tal_link_if.host         link,
  // Software port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic [31:0]      rdData
);
  // Offsets: 0 command (wr: [0]go [1]read [4:2]ptr [11:5]slave), 1 write word, 2 status/read word
  localparam logic [3:0] OffCmd  = 4'h0;
  localparam logic [3:0] OffData = 4'h1;
  localparam logic [3:0] OffStat = 4'h2;

  typedef enum {HsIdle, HsStart, HsBit, HsStop} tal_hst_t;

  typedef struct packed {
    tal_hst_t    st;
    logic [7:0]  div;
    logic [1:0]  ph;
    logic [5:0]  bitIdx;
    logic [44:0] seq;
    logic [44:0] isAck;
    logic [5:0]  nBits;
    logic        read;
    logic [15:0] rx;
    logic        nak;
    logic        sclOe;
    logic        sdaOe;
    logic [31:0] rdData;
    logic        busy;
  } tal_host_t;

  tal_host_t s_r;
  tal_host_t s_nxt;
  logic      sclS;
  logic      sdaS;

  tal_sync uSync (
    .mclk    (mclk),
    .reset   (reset),
    .sclkIn  (link.sclk),
    .sdaIn   (link.sda),
    .sclkOut (sclS),
    .sdaOut  (sdaS)
  );

  assign link.sclkHostOe = s_r.sclOe;
  assign link.sdaHostOe  = s_r.sdaOe;
  assign rdData          = s_r.rdData;

  // Quarter-bit sequencer; each bit is four phases of HostHalfDiv cycles
  always_comb begin
    logic [6:0] a;
    logic       bitV;
    s_nxt = s_r;
    a = wrData[11:5];
    bitV = 1'b1;
    s_nxt.rdData = 32'h0;
    if (rdStb) begin
      s_nxt.rdData = (addr == OffStat) ? {14'h0, s_r.nak, s_r.busy, s_r.rx} : 32'h0;
    end
    if (s_r.st != HsIdle) begin
      s_nxt.div = (s_r.div == 8'(tal_pkg::HostHalfDiv - 1)) ? 8'h0 : s_r.div + 8'h1;
    end
    unique case (s_r.st)
      HsIdle: if (wrStb && addr == OffCmd && wrData[0] && sclS && sdaS) begin
        s_nxt.read = wrData[1];
        s_nxt.busy = 1'b1;
        s_nxt.nak = 1'b0;
        s_nxt.div = 8'h0;
        s_nxt.ph = 2'h0;
        s_nxt.bitIdx = 6'h0;
        // Read: addr+ack, then two bytes with ack then no-ack
        // Write: addr, ptr, two data bytes, each with ack slot
        s_nxt.seq = wrData[1] ? {a, 1'b1, 1'b1, 8'hFF, 1'b0, 8'hFF, 1'b1, 18'h0}
                              : {a, 1'b0, 1'b1, 5'h0, wrData[4:2], 1'b1,
                                 s_r.rx[15:8], 1'b1, s_r.rx[7:0], 1'b1, 9'h000};
        s_nxt.isAck = {8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 9'h0};
        s_nxt.nBits = wrData[1] ? 6'h1B : 6'h24;
        s_nxt.sdaOe = 1'b0;
        s_nxt.st = HsStart;
      end else if (wrStb && addr == OffData) begin
        s_nxt.rx = wrData[15:0];
      end
      HsStart: if (s_r.div == 8'(tal_pkg::HostHalfDiv - 1)) begin
        s_nxt.sclOe = 1'b0;
        s_nxt.st = HsBit;
      end
      HsBit: if (s_r.div == 8'(tal_pkg::HostHalfDiv - 1)) begin
        s_nxt.ph = s_r.ph + 2'h1;
        bitV = s_r.seq[44];
        unique case (s_r.ph)
          2'h0: s_nxt.sdaOe = bitV;
          2'h1: s_nxt.sclOe = 1'b1;
          2'h2: begin
            if (s_r.isAck[44] && !s_r.read && sdaS) s_nxt.nak = 1'b1;
            if (s_r.read && !s_r.isAck[44] && s_r.bitIdx >= 6'h09) begin
              s_nxt.rx = {s_r.rx[14:0], sdaS};
            end
            if (s_r.read && s_r.bitIdx == 6'h08 && sdaS) s_nxt.nak = 1'b1; // Address refused
          end
          2'h3: begin
            s_nxt.sclOe = 1'b0;
            s_nxt.seq = {s_r.seq[43:0], 1'b1};
            s_nxt.isAck = {s_r.isAck[43:0], 1'b0};
            s_nxt.bitIdx = s_r.bitIdx + 6'h1;
            if (s_r.bitIdx + 6'h1 == s_r.nBits) s_nxt.st = HsStop;
          end
        endcase
      end
      HsStop: if (s_r.div == 8'(tal_pkg::HostHalfDiv - 1)) begin
        s_nxt.ph = s_r.ph + 2'h1;
        unique case (s_r.ph)
          2'h0: s_nxt.sdaOe = 1'b0;
          2'h1: s_nxt.sclOe = 1'b1;
          2'h2: s_nxt.sdaOe = 1'b1;
          2'h3: begin
            s_nxt.busy = 1'b0;
            s_nxt.st = HsIdle;
          end
        endcase
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r       <= '0;
      s_r.st    <= HsIdle;
      s_r.sclOe <= 1'b1;
      s_r.sdaOe <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ---- verification/tal_assertions.sv ----
module tal_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link wires
  input wire logic sclk,
  input wire logic sda,
  // Pull enables
  input wire logic sclkDevOe,
  input wire logic sdaDevOe,
  input wire logic sclkHostOe,
  input wire logic sdaHostOe
);
  // ****************************************
  // Link checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Device end
  dev_sda_change_a: assert property ($changed(sdaDevOe) |-> !sclk)
    else $error("device data moved while clock high");
  ack_hold_a: assert property (!sdaDevOe && sclk |=> !sdaDevOe || !sclk)
    else $error("device ack dropped while clock high");
  stop_release_a: assert property ($rose(sda) && sclk |-> $past(sdaDevOe))
    else $error("device still pulling data at stop");
  dev_no_clock_a: assert property (sclkDevOe)
    else $error("device pulled the clock line");
  dev_idle_release_a: assert property ($rose(sda) && sclk |=> sdaDevOe [*8])
    else $error("device pulled data on an idle bus");
  // Host end
  host_setup_a: assert property ($rose(sclk) |-> sdaHostOe == $past(sdaHostOe, 2))
    else $error("host data not settled before clock rise");
  clock_low_width_a: assert property ($fell(sclkHostOe) |=> !sclkHostOe [*7])
    else $error("host clock low phase too short");
  start_clock_a: assert property ($fell(sda) && sclk |-> ##[1:200] !sclk)
    else $error("no clock after start");
  stop_idle_a: assert property ($rose(sda) && sclk |=> (sda && sclk) [*8])
    else $error("bus not idle after stop");
endmodule

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and constants
  // ****************************************
  logic        mclk;
  logic        reset;
  logic [15:0] sensorTemp;
  logic [3:0]  addr;
  logic [31:0] wrData;
  logic        wrStb;
  logic        rdStb;
  logic [31:0] rdData;
  logic        alertPin;
  logic [15:0] word;
  int          mismatches;
  int          samples_checked;
  localparam logic [6:0]  DevAddr = 7'h1A;
  localparam logic [15:0] IntMode = 16'h0001;
  localparam logic [15:0] PolHigh = 16'h0002;
  localparam logic [15:0] CritOn  = 16'h0004;
  localparam logic [15:0] OutEn   = 16'h0008;
  localparam logic [15:0] IntClr  = 16'h0020;
  localparam logic [15:0] Locks   = 16'h00C0;
  localparam logic [15:0] Shdn    = 16'h0100;
  localparam logic [15:0] T5      = 16'h0050;
  localparam logic [15:0] T20     = 16'h0140;
  localparam logic [15:0] T35     = 16'h0230;
  localparam logic [15:0] T55     = 16'h0370;
  localparam logic [15:0] Up30    = 16'h01E0;
  localparam logic [15:0] T27     = 16'h01B0;
  localparam logic [15:0] Hyst6   = 16'h0600;

  // Both ends joined over one link
  tal_link_if i_tal_link_if ();
  tal_device #(.ConvCyc(20)) i_tal_device (
    .mclk       (mclk),
    .reset      (reset),
    .link       (i_tal_link_if),
    .addrStrap  (3'h2),
    .sensorTemp (sensorTemp),
    .alertPin   (alertPin)
  );
  tal_host i_tal_host (
    .mclk   (mclk),
    .reset  (reset),
    .link   (i_tal_link_if),
    .addr   (addr),
    .wrData (wrData),
    .wrStb  (wrStb),
    .rdStb  (rdStb),
    .rdData (rdData)
  );
  tal_assertions chk (
    .mclk       (mclk),
    .reset      (reset),
    .sclk       (i_tal_link_if.sclk),
    .sda        (i_tal_link_if.sda),
    .sclkDevOe  (i_tal_link_if.sclkDevOe),
    .sdaDevOe   (i_tal_link_if.sdaDevOe),
    .sclkHostOe (i_tal_link_if.sclkHostOe),
    .sdaHostOe  (i_tal_link_if.sdaHostOe)
  );

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask
  // One link transfer, waits for busy to drop
  task automatic xfer(input logic rd, input logic [2:0] p, input logic [6:0] sa,
                      input logic [15:0] wd, input logic nk);
    logic [31:0] st;
    int          n;
    hw(4'h1, {16'h0000, wd});
    hw(4'h0, {20'h00000, sa, p, rd, 1'b1});
    n = 0;
    hr(4'h2, st);
    while (st[16] !== 1'b0 && n < 5000) begin
      hr(4'h2, st);
      n++;
    end
    check_bit(st[16], 1'b0);
    check_bit(st[17], nk);
    word = st[15:0];
  endtask
  task automatic cfg(input logic [15:0] v);
    xfer(1'b0, tal_pkg::PtrSettings, DevAddr, v, 1'b0);
  endtask
  task automatic rdreg(input logic [2:0] p, input logic [15:0] wd, input logic [15:0] exp);
    xfer(1'b0, p, DevAddr, wd, 1'b0);
    xfer(1'b1, p, DevAddr, 16'h0000, 1'b0);
    check_word(word, exp);
  endtask
  task automatic temp(input logic [15:0] t);
    @(posedge mclk);
    sensorTemp <= t;
  endtask
  // Hold: fixed wait; else bounded wait for the level
  task automatic alert_is(input logic exp, input bit hold);
    int n;
    n = 0;
    if (hold) begin
      repeat (300) @(posedge mclk);
    end
    while (!hold && alertPin !== exp && n < 300) begin
      @(posedge mclk);
      n++;
    end
    #1 check_bit(alertPin, exp);
  endtask
  task automatic report_and_stop;
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults;
    alert_is(1'b1, 1);
    rdreg(tal_pkg::PtrCapab, 16'hFFFF, 16'h000F);
    rdreg(tal_pkg::PtrSettings, 16'h0000, 16'h0000);
    rdreg(tal_pkg::PtrSettings, OutEn, 16'h0018);
    alert_is(1'b0, 0);
    $display("test defaults done");
  endtask
  task automatic t_compare;
    xfer(1'b0, tal_pkg::PtrUpper, DevAddr, Up30, 1'b0);
    xfer(1'b0, tal_pkg::PtrLower, DevAddr, 16'h00A0, 1'b0);
    xfer(1'b0, tal_pkg::PtrCrit, DevAddr, 16'h0320, 1'b0);
    alert_is(1'b1, 0);
    temp(T35);
    alert_is(1'b0, 0);
    cfg(OutEn | PolHigh);
    alert_is(1'b1, 0);
    temp(T20);
    alert_is(1'b0, 0);
    temp(T5);
    alert_is(1'b1, 0);
    temp(T20);
    cfg(OutEn);
    alert_is(1'b1, 0);
    cfg(OutEn | Hyst6);
    temp(T35);
    alert_is(1'b0, 0);
    temp(T27);
    alert_is(1'b0, 1);
    temp(T20);
    alert_is(1'b1, 0);
    $display("test comparator done");
  endtask
  task automatic t_interrupt;
    cfg(OutEn | IntMode | IntClr);
    temp(T35);
    alert_is(1'b0, 0);
    temp(T20);
    alert_is(1'b0, 1);
    cfg(OutEn | IntMode | IntClr);
    alert_is(1'b1, 0);
    temp(T35);
    alert_is(1'b0, 0);
    cfg(OutEn | IntMode | Shdn);
    alert_is(1'b0, 1);
    cfg(OutEn | IntMode | Shdn | IntClr);
    alert_is(1'b1, 0);
    $display("test interrupt done");
  endtask
  task automatic t_critical;
    cfg(OutEn | CritOn | IntMode | IntClr);
    alert_is(1'b1, 1);
    temp(T55);
    alert_is(1'b0, 0);
    temp(T20);
    alert_is(1'b1, 0);
    cfg(OutEn | IntMode | IntClr);
    temp(T55);
    alert_is(1'b0, 0);
    cfg(OutEn | IntMode | IntClr);
    alert_is(1'b0, 1);
    temp(T35);
    alert_is(1'b1, 0);
    $display("test critical done");
  endtask
  task automatic t_shutdown;
    temp(T20);
    cfg(OutEn | IntClr);
    alert_is(1'b1, 0);
    temp(T35);
    alert_is(1'b0, 0);
    cfg(OutEn | Shdn);
    temp(T20);
    alert_is(1'b0, 1);
    rdreg(tal_pkg::PtrAmbient, 16'h0000, T35);
    cfg(OutEn);
    alert_is(1'b1, 0);
    $display("test shutdown done");
  endtask
  task automatic t_lock_reset;
    xfer(1'b0, tal_pkg::PtrUpper, 7'h1B, 16'h0100, 1'b1);
    cfg(OutEn | Locks);
    rdreg(tal_pkg::PtrUpper, 16'h0100, Up30);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    alert_is(1'b1, 1);
    rdreg(tal_pkg::PtrUpper, 16'h0100, 16'h0100);
    $display("test lock and reset done");
  endtask

  // ****************************************
  // Clock, run and watchdog
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500000; // About two and a half times the expected run
    mismatches++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    mismatches = 0;
    samples_checked = 0;
    reset = 1'b1;
    addr = 4'h0;
    wrData = 32'h00000000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    sensorTemp = T20;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    t_defaults();
    t_compare();
    t_interrupt();
    t_critical();
    t_shutdown();
    t_lock_reset();
    report_and_stop();
  end
endmodule
